// [design/owr_defs.svh]
`ifndef OWR_DEFS_SVH
`define OWR_DEFS_SVH

// ----------------------------------------------------------------------
// Clock and conversion helpers
// ----------------------------------------------------------------------
`define OWR_CLK_NS        40
// Least times round up, longest times round down, never below one cycle
`define OWR_MIN_CYC(ns)   (((ns) + `OWR_CLK_NS - 1) / `OWR_CLK_NS)
`define OWR_MAX_CYC(ns)   (((ns) / `OWR_CLK_NS) > 0 ? \
                           ((ns) / `OWR_CLK_NS) : 1)

// ----------------------------------------------------------------------
// Line timing in nanoseconds
// ----------------------------------------------------------------------
`define OWR_T_START_NS    2000
`define OWR_END_OF_STREAM_TIME_NS      2000
`define OWR_T_DELAY_NS    100000
`define OWR_T_ENTRY_NS    260000
`define OWR_T_WIN_NS      1000000
`define OWR_T_SHDN_NS     2500000
`define OWR_T_ACK_NS      512000
`define OWR_T_VAL_NS      4000

// ----------------------------------------------------------------------
// Timing in clock cycles
// ----------------------------------------------------------------------
`define OWR_DELAY_CYC     `OWR_MIN_CYC(`OWR_T_DELAY_NS)
`define OWR_ENTRY_CYC     `OWR_MIN_CYC(`OWR_T_ENTRY_NS)
`define OWR_WIN_CYC       `OWR_MAX_CYC(`OWR_T_WIN_NS)
`define OWR_SHDN_CYC      `OWR_MIN_CYC(`OWR_T_SHDN_NS)
`define OWR_ACK_CYC       `OWR_MAX_CYC(`OWR_T_ACK_NS)
`define OWR_VAL_CYC       `OWR_MIN_CYC(`OWR_T_VAL_NS)

// ----------------------------------------------------------------------
// Frame layout and reset values
// ----------------------------------------------------------------------
`define OWR_FRAME_BITS    16
`define OWR_ACK_REQ_BIT   7
`define OWR_SUB_HI_BIT    6
`define OWR_SUB_LO_BIT    5
`define OWR_LEVEL_MSB     4
`define OWR_LEVEL_LSB     0
`define OWR_LEVEL_RST     5'h1F
`define OWR_CNT_MAX       16'hFFFF

`endif

// [design/owr_pkg.sv]
package owr_pkg;

  // Receiver and mode states
  typedef enum logic [2:0] {
    OWR_ST_OFF    = 3'b000,
    OWR_ST_DETECT = 3'b001,
    OWR_ST_DUTY   = 3'b010,
    OWR_ST_RX     = 3'b011,
    OWR_ST_COMMIT = 3'b100,
    OWR_ST_VAL    = 3'b101,
    OWR_ST_ACK    = 3'b110
  } owr_state_t;

  typedef logic [4:0]  owr_level_t;
  typedef logic [15:0] owr_cnt_t;

endpackage

// [design/owr_buf.sv]
`timescale 1ns/1ps

// Two-entry buffer; head entry sits in a flop so outputs are registered
module owr_buf #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         ce_in,
  // Fill side
  input  wire logic         in_valid_in,
  input  wire logic [W-1:0] in_data_in,
  output      logic         in_ready_out,
  // Drain side
  output      logic         out_valid_out,
  output      logic [W-1:0] out_data_out,
  input  wire logic         out_ready_in
);

  logic [W-1:0] mem_q [2];
  logic [1:0]   cnt_q;
  logic [1:0]   cnt_d;
  logic [1:0]   left;
  wire          push = in_valid_in & in_ready_out;
  wire          pop  = out_valid_out & out_ready_in;

  // Full only at two entries, so a stalled drain really blocks filling
  assign in_ready_out = (cnt_q != 2'h2);
  assign left         = cnt_q - {1'b0, pop};
  assign cnt_d        = left + {1'b0, push};
  assign out_data_out = mem_q[0];

  // Occupancy and head/tail storage
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q         <= 2'h0;
      out_valid_out <= 1'b0;
      for (int i = 0; i < 2; i++) begin
        mem_q[i] <= '0;
      end
    end else if (ce_in) begin
      cnt_q         <= cnt_d;
      out_valid_out <= (cnt_d != 2'h0);
      if (pop && cnt_q == 2'h2) begin
        mem_q[0] <= mem_q[1];
      end
      if (push) begin
        mem_q[left[0]] <= in_data_in;
      end
    end
  end

endmodule

// [design/owr_top.sv]
`timescale 1ns/1ps
`include "owr_defs.svh"

// Function
// - Bytes shift in MSB first.
// - Already-high line needs no start.
// - Bit spans fall to fall, decoded then.
// - One if high>=2x low, zero if low>=2x high, else error.
// - Data bit 7 requests acknowledge.
// - Ack needs request, address match, 16 bits.
// - Pull-down after validation delay, 512 us max.
// - No new frame during pull-down.
// - Mode chosen each enable, duty default.
// - Rise, wait 100 us, low over 260 us.
// - Low completes within 1 ms window.
// - Enter one-wire mode at once.
// - Mode locked until 2.5 ms low shutdown.
// - Sub-address bits zero, level in 4:0.
// - Level resets to full scale 31.
// - Address mismatch: no update, no ack.
module owr_top
  import owr_pkg::*;
#(
  // Device address; value is arbitrary
  parameter logic [7:0]  DEV_ADDR  = 8'h5A,
  parameter logic [15:0] ENTRY_CYC = 16'(`OWR_ENTRY_CYC),
  parameter logic [15:0] WIN_CYC   = 16'(`OWR_WIN_CYC),
  parameter logic [15:0] SHDN_CYC  = 16'(`OWR_SHDN_CYC),
  parameter logic [15:0] ACK_CYC   = 16'(`OWR_ACK_CYC)
) (
  // Clock, reset, enable
  input  wire logic       core_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       ce_in,
  // Control line (open-drain)
  input  wire logic       ctrl_in,
  output      logic       ctrl_out,
  output      logic       ctrl_oe_out,
  // Mode and level status
  output      logic       enabled_out,
  output      logic       one_wire_mode_out,
  output      logic       duty_mode_out,
  output      owr_level_t feedback_reference_out,
  output      logic       frame_error_out,
  // Accepted data bytes
  output      logic       cmd_valid_out,
  output      logic [7:0] cmd_data_out,
  input  wire logic       cmd_ready_in
);

  // --------------------------------------------------------------------
  // Timing constants
  // --------------------------------------------------------------------
  localparam owr_cnt_t DELAY_CYC = 16'(`OWR_DELAY_CYC);
  localparam owr_cnt_t VAL_CYC   = 16'(`OWR_VAL_CYC);
  localparam owr_cnt_t CNT_MAX   = `OWR_CNT_MAX;

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  owr_state_t  st_q;
  logic        line_q;
  owr_cnt_t    lo_run_q;
  owr_cnt_t    tim_q;
  owr_cnt_t    lo_q;
  owr_cnt_t    hi_q;
  logic        fall_ok_q;
  logic        bit_act_q;
  logic [3:0]  nbit_q;
  logic        err_q;
  logic [15:0] sh_q;
  logic        pd_q;
  logic        en_q;
  logic        ow_q;
  logic        duty_q;
  owr_level_t  level_q;
  logic        ferr_q;

  // ratio bit decode, returns {valid, value}
  function automatic logic [1:0] owr_bit(input owr_cnt_t lo,
                                         input owr_cnt_t hi);
    if ({1'b0, hi} >= {lo, 1'b0}) begin
      owr_bit = 2'b11;
    end else if ({1'b0, lo} >= {hi, 1'b0}) begin
      owr_bit = 2'b10;
    end else begin
      owr_bit = 2'b00;
    end
  endfunction

  // --------------------------------------------------------------------
  // Decoding
  // --------------------------------------------------------------------
  // Line is synchronous to the clock, so one flop suffices for edges
  wire        fall      = line_q & ~ctrl_in;
  wire [1:0]  bit_dec   = owr_bit(lo_q, hi_q);
  wire        shdn      = (lo_run_q >= SHDN_CYC);
  wire        tim_sat   = (tim_q == CNT_MAX);
  wire        last_bit  = (nbit_q == 4'(`OWR_FRAME_BITS - 1));
  wire        entry_hit = !ctrl_in && fall_ok_q &&
                          (lo_run_q > ENTRY_CYC) && (tim_q < WIN_CYC);
  wire        frame_ok  = !err_q && (sh_q[15:8] == DEV_ADDR) &&
                          !sh_q[`OWR_SUB_HI_BIT] && !sh_q[`OWR_SUB_LO_BIT];
  wire        buf_rdy;
  wire        buf_push  = (st_q == OWR_ST_COMMIT) && frame_ok;

  // Only the low level is ever driven onto the line
  assign ctrl_out               = 1'b0;
  assign ctrl_oe_out            = pd_q;
  assign enabled_out            = en_q;
  assign one_wire_mode_out      = ow_q;
  assign duty_mode_out          = duty_q;
  assign feedback_reference_out = level_q;
  assign frame_error_out        = ferr_q;

  // --------------------------------------------------------------------
  // Line history and low-run counter
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      line_q   <= 1'b0;
      lo_run_q <= '0;
    end else if (ce_in) begin
      line_q   <= ctrl_in;
      lo_run_q <= ctrl_in ? '0 : (lo_run_q == CNT_MAX ? lo_run_q
                                                      : lo_run_q + 1'b1);
    end
  end

  // --------------------------------------------------------------------
  // Mode selection, bit receiver and acknowledge
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q      <= OWR_ST_OFF;
      tim_q     <= '0;
      lo_q      <= '0;
      hi_q      <= '0;
      fall_ok_q <= 1'b0;
      bit_act_q <= 1'b0;
      nbit_q    <= 4'h0;
      err_q     <= 1'b0;
      sh_q      <= 16'h0000;
      pd_q      <= 1'b0;
      en_q      <= 1'b0;
      ow_q      <= 1'b0;
      duty_q    <= 1'b0;
      level_q   <= `OWR_LEVEL_RST;
      ferr_q    <= 1'b0;
    end else if (ce_in) begin
      tim_q <= tim_sat ? tim_q : tim_q + 1'b1;
      case (st_q)
        OWR_ST_OFF: begin
          if (ctrl_in) begin
            st_q      <= OWR_ST_DETECT;
            tim_q     <= '0;
            fall_ok_q <= 1'b0;
            en_q      <= 1'b1;
            level_q   <= `OWR_LEVEL_RST;
          end
        end
        OWR_ST_DETECT: begin
          if (fall) begin
            fall_ok_q <= (tim_q >= DELAY_CYC);
          end
          if (shdn) begin
            st_q <= OWR_ST_OFF;
            en_q <= 1'b0;
          end else if (entry_hit) begin
            st_q      <= OWR_ST_RX;
            ow_q      <= 1'b1;
            bit_act_q <= 1'b0;
            nbit_q    <= 4'h0;
            err_q     <= 1'b0;
          end else if (tim_q >= WIN_CYC) begin
            st_q   <= OWR_ST_DUTY;
            duty_q <= 1'b1;
          end
        end
        OWR_ST_DUTY: begin
          if (shdn) begin
            st_q   <= OWR_ST_OFF;
            en_q   <= 1'b0;
            duty_q <= 1'b0;
          end
        end
        OWR_ST_RX: begin
          if (shdn) begin
            st_q <= OWR_ST_OFF;
            en_q <= 1'b0;
            ow_q <= 1'b0;
          end else if (fall) begin
            // first fall simply opens a bit
            lo_q <= '0;
            hi_q <= '0;
            if (bit_act_q) begin
              sh_q      <= {sh_q[14:0], bit_dec[0]};
              err_q     <= err_q | ~bit_dec[1];
              nbit_q    <= nbit_q + 1'b1;
              bit_act_q <= (nbit_q[2:0] != 3'h7);
              if (last_bit) begin
                st_q  <= OWR_ST_COMMIT;
                tim_q <= '0;
              end
            end else begin
              bit_act_q <= 1'b1;
            end
          end else if (bit_act_q) begin
            if (ctrl_in) begin
              hi_q <= (hi_q == CNT_MAX) ? hi_q : hi_q + 1'b1;
            end else begin
              lo_q <= (lo_q == CNT_MAX) ? lo_q : lo_q + 1'b1;
            end
            // A stuck high bit drops the partial frame to resync
            if (hi_q == CNT_MAX) begin
              bit_act_q <= 1'b0;
              nbit_q    <= 4'h0;
              err_q     <= 1'b0;
            end
          end
        end
        OWR_ST_COMMIT: begin
          if (!frame_ok) begin
            st_q   <= OWR_ST_RX;
            ferr_q <= 1'b1;
            nbit_q <= 4'h0;
            err_q  <= 1'b0;
          end else if (buf_rdy) begin
            level_q <= sh_q[`OWR_LEVEL_MSB:`OWR_LEVEL_LSB];
            ferr_q  <= 1'b0;
            nbit_q  <= 4'h0;
            err_q   <= 1'b0;
            st_q    <= sh_q[`OWR_ACK_REQ_BIT] ? OWR_ST_VAL : OWR_ST_RX;
          end
        end
        OWR_ST_VAL: begin
          // wait validation delay from last fall
          if (tim_q >= VAL_CYC - 1'b1) begin
            st_q  <= OWR_ST_ACK;
            tim_q <= '0;
            pd_q  <= 1'b1;
          end
        end
        OWR_ST_ACK: begin
          if (tim_q >= ACK_CYC - 1'b1) begin
            st_q      <= OWR_ST_RX;
            pd_q      <= 1'b0;
            bit_act_q <= 1'b0;
          end
        end
        default: begin
          st_q <= OWR_ST_OFF;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Output buffer for accepted data bytes
  // --------------------------------------------------------------------
  // A full buffer holds the frame in commit, so no byte is lost
  owr_buf #(.W(8)) owr_buf_inst (
    .clk_in        (core_clk_in),
    .rst_n_in      (rst_n_in),
    .ce_in         (ce_in),
    .in_valid_in   (buf_push),
    .in_data_in    (sh_q[7:0]),
    .in_ready_out  (buf_rdy),
    .out_valid_out (cmd_valid_out),
    .out_data_out  (cmd_data_out),
    .out_ready_in  (cmd_ready_in)
  );
endmodule

// [tb/owr_top_chk.sv]
`timescale 1ns/1ps
// ------
// Port checker
// ------
module owr_top_chk
  import owr_pkg::*;
#(
  parameter logic [15:0] ACK_CYC = 16'h3200
) (
  // Clock and line
  input wire logic       core_clk_in,
  input wire logic       rst_n_in,
  input wire logic       ce_in,
  input wire logic       ctrl_in,
  input wire logic       ctrl_out,
  input wire logic       ctrl_oe_out,
  // Status and bytes
  input wire logic       enabled_out,
  input wire logic       one_wire_mode_out,
  input wire logic       duty_mode_out,
  input wire owr_level_t feedback_reference_out,
  input wire logic       cmd_valid_out,
  input wire logic [7:0] cmd_data_out,
  input wire logic       cmd_ready_in
);
  logic [15:0] oe_cnt_q;
  logic [15:0] fall_age_q;
  logic        line_q;

  // Pulse length, and age of the last falling edge on the line
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      oe_cnt_q   <= 16'h0000;
      fall_age_q <= 16'h0000;
      line_q     <= 1'b0;
    end else begin
      oe_cnt_q   <= ctrl_oe_out ? oe_cnt_q + 16'h0001 : 16'h0000;
      fall_age_q <= (line_q && !ctrl_in) ? 16'h0000 : fall_age_q + 16'h0001;
      line_q     <= ctrl_in;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_drive_low_only: assert property (ctrl_out == 1'b0)
    else $error("ctrl_out not low");
  a_modes_apart: assert property (!(one_wire_mode_out && duty_mode_out))
    else $error("both modes set");
  a_mode_locked: assert property (($fell(one_wire_mode_out) ||
      $fell(duty_mode_out)) |-> !enabled_out)
    else $error("mode dropped while enabled");
  a_enable_on_high: assert property (ce_in && !enabled_out &&
      ctrl_in |=> enabled_out)
    else $error("no enable on high line");
  a_level_only_1w: assert property ($changed(feedback_reference_out) &&
      feedback_reference_out != 5'h1F |-> one_wire_mode_out)
    else $error("level moved outside one-wire mode");
  a_ack_length: assert property ($fell(ctrl_oe_out) |->
      oe_cnt_q == ACK_CYC)
    else $error("ack pulse length wrong");
  a_ack_delay: assert property ($rose(ctrl_oe_out) |->
      fall_age_q >= 16'h0062 && fall_age_q <= 16'h0068)
    else $error("ack not after validation delay");
  a_cmd_hold: assert property (cmd_valid_out && !cmd_ready_in |=>
      cmd_valid_out ##0 $stable(cmd_data_out))
    else $error("byte lost under stall");
endmodule

bind owr_top owr_top_chk #(.ACK_CYC(ACK_CYC)) owr_top_chk_inst (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
  .ctrl_in(ctrl_in), .ctrl_out(ctrl_out), .ctrl_oe_out(ctrl_oe_out),
  .enabled_out(enabled_out), .one_wire_mode_out(one_wire_mode_out),
  .duty_mode_out(duty_mode_out),
  .feedback_reference_out(feedback_reference_out),
  .cmd_valid_out(cmd_valid_out), .cmd_data_out(cmd_data_out),
  .cmd_ready_in(cmd_ready_in));

// [tb/owr_host_model.sv]
`timescale 1ns/1ps
// ------
// Host on the control line
// ------
module owr_host_model (
  // Clock
  input  wire logic core_clk_in,
  // Line
  input  wire logic ctrl_oe_out,
  output      logic ctrl_line_out
);
  logic host_low_q = 1'b1;

  // pull-up; low when either side pulls
  assign ctrl_line_out = !(host_low_q || ctrl_oe_out);

  // Hold a level for n cycles, changing just after an edge
  task automatic hold(input logic lvl, input int n);
    host_low_q = !lvl;
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask

  // fall to fall, 3 to 1 ratio; broken makes halves equal
  task automatic send_bit(input logic b, input logic broken);
    int lo;
    lo = broken ? 8 : (b ? 4 : 12);
    hold(1'b0, lo);
    hold(1'b1, 16 - lo);
  endtask

  task automatic send_byte(input logic [7:0] v, input logic broken);
    for (int i = 7; i >= 0; i--) begin
      send_bit(v[i], broken && i == 3);
    end
  endtask

  // start, end, ack sample, wait out pull-down
  task automatic send_frame(input logic [7:0] addr, input logic [7:0] data,
                            input logic broken, output logic ack_seen);
    hold(1'b1, 60);
    send_byte(addr, 1'b0);
    hold(1'b0, 60);
    hold(1'b1, 60);
    send_byte(data, broken);
    hold(1'b0, 110);
    hold(1'b1, 5);
    ack_seen = !ctrl_line_out;
    hold(1'b1, 60);
  endtask
endmodule

// [tb/owr_top_tb_top.sv]
`timescale 1ns/1ps
// ------
// Bench top
// ------
module owr_top_tb_top;
  import owr_pkg::*;
  localparam logic [7:0] ADDR = 8'h5A;
  logic       core_clk_in = 1'b0;
  logic       rst_n_in    = 1'b0;
  logic       cmd_ready_in = 1'b1;
  logic       ce_in        = 1'b1;
  wire        ctrl_in;
  logic       ctrl_out, ctrl_oe_out, enabled_out, one_wire_mode_out;
  logic       duty_mode_out, frame_error_out, cmd_valid_out, ack;
  owr_level_t feedback_reference_out;
  logic [7:0] cmd_data_out, last_cmd;
  int         miscompares = 0, checked = 0, cycles = 0, taken = 0;

  // Short counts keep the run brief
  owr_top #(.DEV_ADDR(ADDR), .ENTRY_CYC(16'h0032), .WIN_CYC(16'h0BB8),
            .SHDN_CYC(16'h012C), .ACK_CYC(16'h0014)) owr_top_inst (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .ctrl_in(ctrl_in), .ctrl_out(ctrl_out), .ctrl_oe_out(ctrl_oe_out),
    .enabled_out(enabled_out), .one_wire_mode_out(one_wire_mode_out),
    .duty_mode_out(duty_mode_out),
    .feedback_reference_out(feedback_reference_out),
    .frame_error_out(frame_error_out), .cmd_valid_out(cmd_valid_out),
    .cmd_data_out(cmd_data_out), .cmd_ready_in(cmd_ready_in));
  owr_host_model owr_host_model_inst (.core_clk_in(core_clk_in),
    .ctrl_oe_out(ctrl_oe_out), .ctrl_line_out(ctrl_in));

  always #20 core_clk_in = ~core_clk_in;

  // Record taken bytes; cut a hang short
  always @(posedge core_clk_in) begin
    cycles++;
    if (cmd_valid_out === 1'b1 && cmd_ready_in === 1'b1) begin
      last_cmd <= cmd_data_out;
      taken++;
    end
    if (cycles == 40000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("Counts: %0d checked, %0d mismatched", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic frame(input logic [7:0] a, input logic [7:0] d,
                       input logic broken);
    owr_host_model_inst.send_frame(a, d, broken, ack);
  endtask

  task automatic t_duty();
    check(8'(feedback_reference_out), 8'h1F, "rst lvl");
    // Qualifying low only completes after the window has closed
    owr_host_model_inst.hold(1'b1, 2960);
    owr_host_model_inst.hold(1'b0, 60);
    owr_host_model_inst.hold(1'b1, 100);
    check(8'(duty_mode_out), 8'h01, "duty");
    check(8'(one_wire_mode_out), 8'h00, "no 1w");
    frame(ADDR, 8'h83, 1'b0);
    check(8'(feedback_reference_out), 8'h1F, "ignored");
    check(8'(ack), 8'h00, "no ack");
    owr_host_model_inst.hold(1'b0, 320);
    check(8'(enabled_out), 8'h00, "off");
    check(8'(duty_mode_out), 8'h00, "cleared");
    $display("Test duty done");
  endtask

  task automatic t_entry();
    // A long low before the detection delay must not count
    owr_host_model_inst.hold(1'b1, 100);
    owr_host_model_inst.hold(1'b0, 60);
    check(8'(one_wire_mode_out), 8'h00, "early");
    owr_host_model_inst.hold(1'b1, 2500);
    owr_host_model_inst.hold(1'b0, 60);
    owr_host_model_inst.hold(1'b1, 20);
    check(8'(one_wire_mode_out), 8'h01, "1w");
    check(8'(duty_mode_out), 8'h00, "no duty");
    check(8'(feedback_reference_out), 8'h1F, "lvl");
    $display("Test entry done");
  endtask

  task automatic t_levels();
    logic [7:0] data [5] = '{8'h00, 8'h15, 8'h0A, 8'h1E, 8'h8C};
    foreach (data[i]) begin
      frame(ADDR, data[i], 1'b0);
      check(8'(feedback_reference_out), data[i] & 8'h1F, "lvl");
      check(last_cmd, data[i], "byte");
      check(8'(ack), 8'(data[i][7]), "ack");
      check(8'(frame_error_out), 8'h00, "err");
    end
    $display("Test levels done");
  endtask

  task automatic t_bad();
    logic [7:0] adr [4] = '{ADDR ^ 8'h01, ADDR, ADDR, ADDR};
    logic [7:0] dat [4] = '{8'h85, 8'hC6, 8'hA6, 8'h86};
    foreach (adr[i]) begin
      frame(adr[i], dat[i], i == 3);
      check(8'(ack), 8'h00, "ack");
      check(8'(feedback_reference_out), 8'h0C, "lvl");
      check(8'(frame_error_out), 8'h01, "err");
    end
    $display("Test reject done");
  endtask

  task automatic t_buffer();
    int n;
    cmd_ready_in = 1'b0;
    frame(ADDR, 8'h03, 1'b0);
    frame(ADDR, 8'h04, 1'b0);
    check(8'(cmd_valid_out), 8'h01, "held");
    check(cmd_data_out, 8'h03, "oldest");
    frame(ADDR, 8'h05, 1'b0);
    check(8'(feedback_reference_out), 8'h04, "waits");
    n = taken;
    cmd_ready_in = 1'b1;
    owr_host_model_inst.hold(1'b1, 12);
    check(8'(taken - n), 8'h03, "drained");
    check(last_cmd, 8'h05, "last");
    check(8'(feedback_reference_out), 8'h05, "lvl");
    $display("Test buffer done");
  endtask

  // frozen clock enable: long low must not shut down
  task automatic t_freeze();
    ce_in = 1'b0;
    owr_host_model_inst.hold(1'b0, 400);
    check(8'(enabled_out), 8'h01, "frozen");
    owr_host_model_inst.hold(1'b1, 20);
    ce_in = 1'b1;
    owr_host_model_inst.hold(1'b1, 20);
    check(8'(one_wire_mode_out), 8'h01, "kept");
    check(8'(feedback_reference_out), 8'h1F, "lvl");
    $display("Test freeze done");
  endtask

  task automatic t_reset();
    rst_n_in = 1'b0;
    owr_host_model_inst.hold(1'b1, 2);
    check(8'(feedback_reference_out), 8'h1F, "por lvl");
    check(8'(one_wire_mode_out), 8'h00, "por mode");
    check(8'(cmd_valid_out), 8'h00, "por byte");
    rst_n_in = 1'b1;
    owr_host_model_inst.hold(1'b1, 2);
    check(8'(enabled_out), 8'h01, "re-enable");
    check(8'(duty_mode_out), 8'h00, "undecided");
    $display("Test reset done");
  endtask

  initial begin
    repeat (8) @(posedge core_clk_in);
    #1;
    rst_n_in = 1'b1;
    t_duty();
    t_entry();
    t_freeze();
    t_levels();
    t_bad();
    t_buffer();
    t_reset();
    print_verdict();
  end
endmodule
